/* File: rtl/ddw_write_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module ddw_write_seq
   import ddw_pkg::*;
#(
   parameter int DQ_W = 16,
   parameter int CWL_MAX = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wr_cmd_pin,
   input wire logic a12_pin,
   input wire logic [2*DQ_W-1:0] dq_pin,
   output logic wdata_ready,
   output logic data_capture,
   output logic wr_recovery_ref
);
   localparam int FW = 2 * DQ_W;
   initial begin
      if (FW > 32 || DQ_W < 1) begin
         $error("ddw_write_seq: two beats must fit in one 32-bit word.");
      end
      if (CWL_MAX < 10 || CWL_MAX > 31) begin
         $error("ddw_write_seq: CWL_MAX must lie in 10..31.");
      end
   end

   // Pins are asynchronous to aclk; each passes two flops. Every pin gets
   // the same delay, so the command-to-data distance is preserved.
   logic cmd_s1, cmd_s2, a12_s1, a12_s2;
   logic [FW-1:0] dq_s1, dq_s2;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_s1 <= 1'b0;
         cmd_s2 <= 1'b0;
         a12_s1 <= 1'b0;
         a12_s2 <= 1'b0;
         dq_s1 <= '0;
         dq_s2 <= '0;
      end else begin
         cmd_s1 <= wr_cmd_pin;
         cmd_s2 <= cmd_s1;
         a12_s1 <= a12_pin;
         a12_s2 <= a12_s1;
         dq_s1 <= dq_pin;
         dq_s2 <= dq_s1;
      end
   end

   logic [1:0] burst_field;
   logic pre2;
   logic [4:0] cwl;
   logic ovf, cwl_bad, ccd_bad;
   logic [15:0] burst_count;

   function automatic ddw_burst_t pick_burst(input logic [1:0] bf, input logic a12);
      ddw_burst_t k;
      k = DDW_BL8;
      unique case (bf)
         BF_BL8: k = DDW_BL8; // RULE_01
         BF_OTF: k = a12 ? DDW_BL8 : DDW_BC4; // RULE_01 RULE_02
         BF_BC4: k = DDW_BC4; // RULE_03
         default: k = DDW_BL8;
      endcase
      return k;
   endfunction

   // A latency outside the supported span is clamped so the slot line stays in range.
   logic [4:0] cwl_eff;
   always_comb begin
      if (cwl < CWL_LOW) begin
         cwl_eff = CWL_LOW;
      end else if (cwl > 5'(CWL_MAX)) begin
         cwl_eff = 5'(CWL_MAX);
      end else begin
         cwl_eff = cwl;
      end
   end

   // Each command drops its own burst kind into the slot that reaches the
   // head after the write latency, so lengths can change command by command.
   ddw_burst_t slot [0:CWL_MAX];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i <= CWL_MAX; i++) begin
            slot[i] <= DDW_NONE;
         end
      end else begin
         for (int i = 0; i < CWL_MAX; i++) begin
            slot[i] <= slot[i+1];
         end
         slot[CWL_MAX] <= DDW_NONE;
         if (cmd_s2) begin
            // The synced command reaches this line one clock after the synced
            // data would, so it drops one slot short of the latency.
            slot[cwl_eff - 5'h01] <= pick_burst(burst_field, a12_s2); // RULE_04
         end
      end
   end

   // Two beats arrive per clock, so a burst occupies four or two clocks.
   logic [2:0] left;
   logic last_beat;
   logic [2:0] start_len;
   assign start_len = (slot[0] == DDW_BL8) ? CLOCKS_BL8 : CLOCKS_BC4;
   assign data_capture = (slot[0] != DDW_NONE) || (left != 3'h0);
   assign last_beat = (slot[0] != DDW_NONE) ? (start_len == 3'h1) : (left == 3'h1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left <= 3'h0;
      end else if (slot[0] != DDW_NONE) begin
         left <= start_len - 3'h1;
      end else if (left != 3'h0) begin
         left <= left - 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_recovery_ref <= 1'b0;
      end else begin
         wr_recovery_ref <= data_capture && last_beat; // RULE_05
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         burst_count <= 16'h0000;
      end else if (wr_recovery_ref) begin
         burst_count <= burst_count + 16'h0001;
      end
   end

   logic [3:0] gap;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap <= GAP_SAT;
      end else if (cmd_s2) begin
         gap <= 4'h1;
      end else if (gap != GAP_SAT) begin
         gap <= gap + 4'h1;
      end
   end

   ddw_fifo_if #(.W(FW)) fq ();
   ddw_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .f(fq.fifo)
   );
   // The memory bus cannot be held off, so a full buffer loses the beat pair
   // and leaves a sticky flag; wdata_ready warns the controller beforehand.
   assign fq.in_data = dq_s2;
   assign fq.in_valid = data_capture;
   assign wdata_ready = fq.in_ready;

   // Register bus: address and data are latched separately, in either order.
   logic aw_held, w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic cfg_wr, stat_wr;
   assign cfg_wr = do_write && (aw_addr == ADDR_CFG);
   assign stat_wr = do_write && (aw_addr == ADDR_STAT) && w_strb[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         burst_field <= BF_RESET;
         pre2 <= 1'b0;
         cwl <= CWL_RESET;
      end else begin
         if (cfg_wr && w_strb[0]) begin
            burst_field <= w_data[CFG_BF_LSB +: 2];
            pre2 <= w_data[CFG_PRE2_BIT];
         end
         if (cfg_wr && w_strb[1]) begin
            cwl <= w_data[CFG_CWL_LSB +: 5];
         end
      end
   end

   // Sticky flags are cleared by writing one; a new event in the same cycle wins.
   logic ovf_set, ccd_set;
   assign ovf_set = fq.in_valid && !fq.in_ready;
   assign ccd_set = cmd_s2 && pre2 && (gap == CCD_FORBIDDEN); // RULE_07
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf <= 1'b0;
         ccd_bad <= 1'b0;
         cwl_bad <= 1'b0;
      end else begin
         ovf <= ovf_set || (ovf && !(stat_wr && w_data[STAT_OVF_BIT]));
         ccd_bad <= ccd_set || (ccd_bad && !(stat_wr && w_data[STAT_CCD_BAD_BIT]));
         cwl_bad <= pre2 && (cwl_eff <= CWL_LOW); // RULE_06
      end
   end

   logic [31:0] stat_word;
   always_comb begin
      stat_word = 32'h00000000;
      stat_word[STAT_NONEMPTY_BIT] = fq.out_valid;
      stat_word[STAT_OVF_BIT] = ovf;
      stat_word[STAT_CWL_BAD_BIT] = cwl_bad;
      stat_word[STAT_CCD_BAD_BIT] = ccd_bad;
      stat_word[STAT_BUSY_BIT] = data_capture;
   end

   logic ar_fire;
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   // A read of the data word pops one beat pair; an empty buffer reads zero.
   assign fq.out_ready = ar_fire && (s_axi_araddr == ADDR_DATA);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         unique case (s_axi_araddr)
            ADDR_CFG: begin
               s_axi_rdata[CFG_BF_LSB +: 2] <= burst_field;
               s_axi_rdata[CFG_PRE2_BIT] <= pre2;
               s_axi_rdata[CFG_CWL_LSB +: 5] <= cwl;
            end
            ADDR_STAT: s_axi_rdata <= stat_word;
            ADDR_DATA: s_axi_rdata[FW-1:0] <= fq.out_valid ? fq.out_data : '0;
            ADDR_CNT: s_axi_rdata[15:0] <= burst_count;
            default: s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: pkg/ddw_pkg.sv */
// Notes on behaviour
// RULE_01: A write moves eight beats when the burst field is 00, or when it is 01 and A12 is high at the command.
// RULE_02: With the burst field at 01, a write taken with A12 low is a four-beat chop.
// RULE_03: With the burst field at 10, every write is a four-beat chop whatever A12 shows.
// RULE_04: In on-the-fly mode each write picks its own length, so eight and four may alternate.
// RULE_05: Write recovery and write-to-read time start at the first rising edge after the last beat.
// RULE_06: In two-clock preamble mode the write latency must sit above its lowest value; nine is illegal.
// RULE_07: In two-clock preamble mode two column commands must not be exactly five clocks apart.
`default_nettype none
package ddw_pkg;
   localparam logic [3:0] ADDR_CFG = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_DATA = 4'h8;
   localparam logic [3:0] ADDR_CNT = 4'hC;
   localparam int CFG_BF_LSB = 0;
   localparam int CFG_PRE2_BIT = 2;
   localparam int CFG_CWL_LSB = 8;
   localparam int STAT_NONEMPTY_BIT = 0;
   localparam int STAT_OVF_BIT = 1;
   localparam int STAT_CWL_BAD_BIT = 2;
   localparam int STAT_CCD_BAD_BIT = 3;
   localparam int STAT_BUSY_BIT = 4;
   localparam logic [1:0] BF_BL8 = 2'h0;
   localparam logic [1:0] BF_OTF = 2'h1;
   localparam logic [1:0] BF_BC4 = 2'h2;
   localparam logic [1:0] BF_RESET = 2'h0;
   localparam logic [4:0] CWL_LOW = 5'h09;
   localparam logic [4:0] CWL_RESET = 5'h09;
   localparam logic [2:0] CLOCKS_BL8 = 3'h4;
   localparam logic [2:0] CLOCKS_BC4 = 3'h2;
   localparam logic [3:0] CCD_FORBIDDEN = 4'h5;
   localparam logic [3:0] GAP_SAT = 4'hF;
   localparam int FIFO_DEPTH = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      DDW_NONE = 2'h0,
      DDW_BC4 = 2'h1,
      DDW_BL8 = 2'h2
   } ddw_burst_t;
endpackage
`default_nettype wire

/* File: pkg/ddw_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ddw_fifo_if #(parameter int W = 32) ();
   logic [W-1:0] in_data;
   logic in_valid;
   logic in_ready;
   logic [W-1:0] out_data;
   logic out_valid;
   logic out_ready;
   modport src (output in_data, output in_valid, input in_ready,
      input out_data, input out_valid, output out_ready);
   modport fifo (input in_data, input in_valid, output in_ready,
      output out_data, output out_valid, input out_ready);
endinterface
`default_nettype wire

/* File: rtl/ddw_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module ddw_fifo
   import ddw_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   ddw_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("ddw_fifo: DEPTH must be a power of two of at least 2.");
      end
   end
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign f.in_ready = !full;
   assign f.out_valid = !empty;
   assign f.out_data = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
      end else if (f.in_valid && !full) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (f.in_valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= f.in_data;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr <= '0;
      end else if (f.out_ready && !empty) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/ddw_write_seq_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module ddw_write_seq_properties
   import ddw_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic data_capture,
   input wire logic wr_recovery_ref
);
   logic [1:0] bf;
   logic wr_hs;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // The copy of the burst field assumes address and data are offered together.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bf <= BF_RESET;
      end else if (wr_hs && s_axi_awaddr == ADDR_CFG) begin
         bf <= s_axi_wdata[1:0];
      end
   end
   property p_ref_after_cap;
      $fell(data_capture) |-> wr_recovery_ref;
   endproperty
   a_ref_after_cap: assert property (p_ref_after_cap) else $error("no pulse after burst");
   property p_ref_single;
      wr_recovery_ref |=> !wr_recovery_ref;
   endproperty
   a_ref_single: assert property (p_ref_single) else $error("pulse too long");
   property p_bl8_run;
      $rose(data_capture) && bf == BF_BL8 |-> data_capture[*4];
   endproperty
   a_bl8_run: assert property (p_bl8_run) else $error("eight-beat burst cut short");
   property p_bc4_run;
      $rose(data_capture) && bf == BF_BC4 |-> data_capture[*2] ##1 !data_capture;
   endproperty
   a_bc4_run: assert property (p_bc4_run) else $error("chop burst length wrong");
   property p_wr_resp;
      wr_hs |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
   property p_no_accept;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_no_accept: assert property (p_no_accept) else $error("write taken during response");
   c_bl8: cover property ($rose(data_capture) && bf == BF_BL8);
   c_otf: cover property (bf == BF_OTF && $fell(data_capture));
   c_ref: cover property (wr_recovery_ref);
endmodule
bind ddw_write_seq ddw_write_seq_properties i_ddw_write_seq_properties (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .data_capture, .wr_recovery_ref);
`default_nettype wire

/* File: bench/ddw_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ddw_ctrl_model (
   input wire logic aclk,
   output logic wr_cmd_pin,
   output logic a12_pin,
   output logic [31:0] dq_pin
);
   int cyc = 0;
   logic [31:0] sched [int];
   initial begin
      wr_cmd_pin = 1'h0;
      a12_pin = 1'h0;
      dq_pin = 32'h0;
   end
   // Outside bursts the lines toggle so a stale beat never looks fresh.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (sched.exists(cyc)) begin
         dq_pin <= sched[cyc];
         sched.delete(cyc);
      end else begin
         dq_pin <= ~dq_pin;
      end
   end
   // The caller picks latency and spacing; nothing here keeps them legal, and t_pre2 passes illegal ones.
   task automatic wr(input logic a12, input int n, input int cwl, input logic [31:0] base);
      @(posedge aclk);
      wr_cmd_pin <= 1'h1;
      a12_pin <= a12;
      for (int i = 0; i < n; i++) begin
         sched[cyc + cwl + i] = base + 32'(i);
      end
      @(posedge aclk);
      wr_cmd_pin <= 1'h0;
      a12_pin <= ~a12;
   endtask
endmodule
`default_nettype wire

/* File: bench/ddw_write_seq_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module ddw_write_seq_bench
   import ddw_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, dq_pin, rdat;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic wr_cmd_pin, a12_pin, wdata_ready, data_capture, wr_recovery_ref;
   int num_errors = 0;
   int n_checks = 0;
   int bursts = 0;
   ddw_write_seq i_ddw_write_seq (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .wr_cmd_pin, .a12_pin, .dq_pin, .wdata_ready, .data_capture, .wr_recovery_ref);
   ddw_ctrl_model i_ddw_ctrl_model (.aclk, .wr_cmd_pin, .a12_pin, .dq_pin);
   initial begin
      aclk = 1'h0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      logic aw, w;
      @(posedge aclk);
      aw = 1'h0;
      w = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (!aw && s_axi_awready === 1'h1) begin
            aw = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (!w && s_axi_wready === 1'h1) begin
            w = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) begin
            s_axi_arvalid <= 1'h0;
         end
      end while (s_axi_rvalid !== 1'h1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic cfg(input logic [1:0] bf, input logic pre2, input logic [4:0] cwl);
      wr_reg(ADDR_CFG, (32'(cwl) << CFG_CWL_LSB) | (32'(pre2) << CFG_PRE2_BIT) | 32'(bf));
   endtask
   task automatic stat_bit(input int b, input logic v);
      rd_reg(ADDR_STAT);
      chk(32'(rdat[b]), 32'(v));
   endtask
   task automatic drain(input logic [31:0] base, input int n);
      for (int i = 0; i < n; i++) begin
         rd_reg(ADDR_DATA);
         chk(rdat, base + 32'(i));
      end
      stat_bit(STAT_NONEMPTY_BIT, 1'h0);
   endtask
   task automatic t_regs();
      rd_reg(ADDR_CFG);
      chk(rdat, (32'(CWL_RESET) << CFG_CWL_LSB) | 32'(BF_RESET));
      rd_reg(ADDR_STAT);
      chk(rdat, 32'h0);
      wr_reg(4'h2, 32'h0);
      chk(32'(resp), 32'(RESP_SLVERR));
      rd_reg(4'h2);
      chk(32'(resp), 32'(RESP_SLVERR));
      $display("regs done");
   endtask
   task automatic t_single(input logic [1:0] bf, input logic a12, input int n, input logic [31:0] b);
      int k;
      cfg(bf, 1'h0, CWL_RESET);
      i_ddw_ctrl_model.wr(a12, n, 9, b);
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (wr_recovery_ref !== 1'h1 && k < 60);
      chk(32'(k), 32'(9 + n + 2));
      bursts++;
      drain(b, n);
      rd_reg(ADDR_CNT);
      chk(rdat & 32'hFFFF, 32'(bursts));
      $display("single burst done");
   endtask
   task automatic pair(input logic [1:0] bf, input logic p2, input logic [4:0] cwl,
         input logic a0, input int n0, input logic a1, input int n1, input int gap,
         input logic [31:0] b);
      cfg(bf, p2, cwl);
      i_ddw_ctrl_model.wr(a0, n0, int'(cwl), b);
      repeat (gap - 2) @(posedge aclk);
      i_ddw_ctrl_model.wr(a1, n1, int'(cwl), b + 32'(n0));
      repeat (40) @(posedge aclk);
   endtask
   task automatic t_otf();
      pair(BF_OTF, 1'h0, 5'h09, 1'h1, 4, 1'h0, 2, 4, 32'h5000);
      drain(32'h5000, 6);
      pair(BF_OTF, 1'h0, 5'h09, 1'h0, 2, 1'h1, 4, 4, 32'h6000);
      drain(32'h6000, 6);
      $display("mixed lengths done");
   endtask
   task automatic t_pre2();
      cfg(BF_BL8, 1'h1, 5'h09);
      stat_bit(STAT_CWL_BAD_BIT, 1'h1);
      pair(BF_BL8, 1'h1, 5'h0A, 1'h1, 4, 1'h1, 4, 5, 32'h7000);
      stat_bit(STAT_CWL_BAD_BIT, 1'h0);
      stat_bit(STAT_CCD_BAD_BIT, 1'h1);
      drain(32'h7000, 8);
      wr_reg(ADDR_STAT, 32'h1 << STAT_CCD_BAD_BIT);
      stat_bit(STAT_CCD_BAD_BIT, 1'h0);
      pair(BF_BL8, 1'h1, 5'h0A, 1'h0, 4, 1'h0, 4, 6, 32'h8000);
      drain(32'h8000, 8);
      stat_bit(STAT_CCD_BAD_BIT, 1'h0);
      $display("preamble mode done");
   endtask
   task automatic t_fill();
      pair(BF_BL8, 1'h0, 5'h09, 1'h1, 4, 1'h1, 4, 4, 32'h9000);
      i_ddw_ctrl_model.wr(1'h1, 4, 9, 32'h9008);
      repeat (20) @(posedge aclk);
      chk(32'(wdata_ready), 32'h0);
      stat_bit(STAT_OVF_BIT, 1'h1);
      drain(32'h9000, 8);
      wr_reg(ADDR_STAT, 32'h1 << STAT_OVF_BIT);
      stat_bit(STAT_OVF_BIT, 1'h0);
      $display("fill done");
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      final_report();
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rdat, resp} = '0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_single(BF_BL8, 1'h0, 4, 32'h1000);
      t_single(BF_OTF, 1'h1, 4, 32'h2000);
      t_single(BF_OTF, 1'h0, 2, 32'h3000);
      t_single(BF_BC4, 1'h1, 2, 32'h4000);
      t_otf();
      t_pre2();
      t_fill();
      final_report();
   end
endmodule
`default_nettype wire
